// ===== ssw_consts.svh
// Constants of the supply supervisor and watchdog: offsets, fields,
// reset values and timing counts.
// Assumes a 50 MHz aclk; the user includes this header once per unit.
// Notes on behaviour
// - Supply below trip asserts threshold flag and resets.
// - Threshold flag releases at once when supply recovers.
// - Resets stay active a full stretch after recovery.
// - Watchdog counts only once both resets are inactive.
// - Kick falling edge clears count, starts new period.
// - Full period without kick trips flag and resets.
// - Trip flag latched low until next kick edge.
// - Open kick input disables watchdog, releases trip flag.
// - Trip flag low while supply below trip point.
// - Watchdog stops counting while supply out of tolerance.
// - Three consecutive low samples at 30 kHz raise interrupt.
// - Interrupt blocked until supply reaches trip point.
// - Only sense input rising releases the interrupt.
// - Interrupt pin floats when supply falls to battery.
// - Power-fail indicator is driven active high.
// - Debounced pushbutton press requests a reset.
// - Reset stretch and timeout use selected timebase.
// - Reset on power-down forces memory enable high.
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH

`define SSW_CLK_NS          20
`define SSW_OFF_CTRL        8'h00
`define SSW_OFF_STATUS      8'h04
`define SSW_CTRL_WD_EN      0
`define SSW_CTRL_KICK       1
`define SSW_CTRL_RESET      2'h1
`define SSW_ST_RESET        0
`define SSW_ST_TRIP         1
`define SSW_ST_IRQ          2
`define SSW_ST_SUPPLY_LOW   3
`define SSW_ST_KICK_OPEN    4
`define SSW_ST_BATTERY      5
`define SSW_FIRST_TICKS     20480
`define SSW_LATER_TICKS     5120
`define SSW_RESET_TICKS     641
`define SSW_EW_SAMPLES      2'h3
`define SSW_SAMPLE_NS       33000
`define SSW_SAMPLE_CYCLES   ((`SSW_SAMPLE_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
`define SSW_INT_TICK_NS     156000
`define SSW_INT_TICK_CYCLES ((`SSW_INT_TICK_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
`define SSW_DEBOUNCE_NS     10000000
`define SSW_DEBOUNCE_CYCLES ((`SSW_DEBOUNCE_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)

`endif

// ===== ssw_pkg.sv
// Types shared by the supply supervisor and watchdog.
// Assumes nothing beyond a SystemVerilog compiler.
package ssw_pkg;
    typedef logic [31:0] ssw_word_type;
    typedef logic [1:0]  ssw_resp_type;
    typedef enum logic [1:0]
    {
        SSW_RESP_OKAY   = 2'b00,
        SSW_RESP_SLVERR = 2'b10
    } ssw_resp_code_type;
endpackage : ssw_pkg

// ===== ssw_proc_model.sv
// Behavioural processor that strobes the watchdog kick pin.
// Assumes the bench clock and a run control from the testbench.
`timescale 1ns/1ns
module ssw_proc_model
#(
    parameter int KICK_CYCLES = 16
)
(
    input  wire logic aclk,
    input  wire logic run,
    output logic      watchdog_kick
);
    int cnt = 0;
    initial watchdog_kick = 1'b1;
    // The low phase lasts four cycles so the two sync flops catch it.
    always @(posedge aclk)
    begin
        cnt <= (cnt >= KICK_CYCLES - 1) ? 0 : cnt + 1;
        watchdog_kick <= !(run && cnt < 4);
    end
endmodule : ssw_proc_model

// ===== ssw_top.sv
// Supply supervisor, watchdog, early-warning filter and AXI4-Lite slave.
// Assumes all pin inputs are asynchronous and analogue results digital.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "ssw_consts.svh"

module ssw_top
#(
    parameter int FIRST_TICKS     = `SSW_FIRST_TICKS,
    parameter int LATER_TICKS     = `SSW_LATER_TICKS,
    parameter int RESET_TICKS     = `SSW_RESET_TICKS,
    parameter int INT_TICK_CYCLES = `SSW_INT_TICK_CYCLES,
    parameter int DEBOUNCE_CYCLES = `SSW_DEBOUNCE_CYCLES
)
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    input  wire logic                  supply_low,
    input  wire logic                  sense_low,
    input  wire logic                  battery_low,
    input  wire logic                  watchdog_kick,
    input  wire logic                  kick_open,
    input  wire logic                  button_n,
    input  wire logic                  timebase_input,
    input  wire logic                  timebase_select,
    input  wire logic                  chip_enable_in_n,
    output logic                       reset_threshold_flag_n,
    output logic                       reset_out_n,
    output logic                       reset_out,
    output logic                       watchdog_trip_flag_n,
    output logic                       ew_irq_n,
    output logic                       ew_irq_oe,
    output logic                       power_fail_flag,
    output logic                       memory_enable_out_n,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire ssw_pkg::ssw_word_type s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output ssw_pkg::ssw_resp_type      s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output ssw_pkg::ssw_word_type      s_axi_rdata,
    output ssw_pkg::ssw_resp_type      s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import ssw_pkg::*;

    localparam int NSYNC = 9;
    localparam int SAMPLE_CYCLES = `SSW_SAMPLE_CYCLES;

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction : fell

    // Two-stage synchronisers; only stage two is read by logic.
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    wire  [NSYNC-1:0] pins = {chip_enable_in_n, timebase_select,
                              timebase_input, button_n, kick_open,
                              watchdog_kick, battery_low, sense_low,
                              supply_low};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= 9'h1B8;
            sync2_reg <= 9'h1B8;
        end
        else if (ce)
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    wire sup_low  = sync2_reg[0];
    wire sen_low  = sync2_reg[1];
    wire bat_low  = sync2_reg[2];
    wire kick_s   = sync2_reg[3];
    wire open_s   = sync2_reg[4];
    wire btn_n_s  = sync2_reg[5];
    wire tb_in_s  = sync2_reg[6];
    wire tb_sel_s = sync2_reg[7];
    wire cei_n_s  = sync2_reg[8];

    logic        kick_prev_reg;
    logic        tb_prev_reg;
    logic [15:0] int_div_reg;
    logic [15:0] smp_div_reg;
    logic [19:0] deb_cnt_reg;
    logic        btn_state_reg;
    logic [9:0]  rst_cnt_reg;
    logic        rst_act_reg;
    logic [14:0] wd_cnt_reg;
    logic        wd_first_reg;
    logic        trip_reg;
    logic [1:0]  ew_cnt_reg;
    logic        ew_reg;
    logic [1:0]  ctrl_reg;

    wire hw_kick  = fell(kick_prev_reg, kick_s) & ~open_s;
    logic kick_evt;
    // Low select picks the external clock, high the internal divider.
    wire ext_tick = tb_in_s && !tb_prev_reg;
    wire int_tick = int_div_reg == 16'(INT_TICK_CYCLES - 1);
    wire tick     = tb_sel_s ? int_tick : ext_tick;
    wire smp_tick = smp_div_reg == 16'(SAMPLE_CYCLES - 1);
    wire deb_done = deb_cnt_reg == 20'(DEBOUNCE_CYCLES - 1);
    wire press    = btn_state_reg && !btn_n_s && deb_done;

    // The watchdog only runs outside reset and with the supply good.
    wire wd_run   = ctrl_reg[`SSW_CTRL_WD_EN] && !open_s && !sup_low
                    && !rst_act_reg;
    wire [14:0] wd_lim = wd_first_reg ? 15'(FIRST_TICKS)
                                      : 15'(LATER_TICKS);
    wire expire   = wd_run && tick && !kick_evt
                    && wd_cnt_reg == wd_lim - 15'h0001;
    // A held button keeps reloading the stretch, so the full duration
    // is counted from the settled release.
    wire rst_req  = sup_low || expire || press
                    || !btn_state_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            kick_prev_reg <= 1'b1;
            tb_prev_reg   <= 1'b0;
            int_div_reg   <= 16'h0000;
            smp_div_reg   <= 16'h0000;
        end
        else if (ce)
        begin
            kick_prev_reg <= kick_s;
            tb_prev_reg   <= tb_in_s;
            int_div_reg   <= int_tick ? 16'h0000 : int_div_reg + 16'h0001;
            smp_div_reg   <= smp_tick ? 16'h0000 : smp_div_reg + 16'h0001;
        end
    end

    // The button level must hold a whole window before it counts, so
    // contact bounce only restarts the window.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            deb_cnt_reg   <= 20'h00000;
            btn_state_reg <= 1'b1;
        end
        else if (ce)
        begin
            if (btn_n_s != btn_state_reg && !deb_done)
                deb_cnt_reg <= deb_cnt_reg + 20'h00001;
            else
                deb_cnt_reg <= 20'h00000;
            if (deb_done)
                btn_state_reg <= btn_n_s;
        end
    end

    // Reset stretch: reloaded by every cause, counted down on ticks.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_cnt_reg <= 10'(RESET_TICKS);
            rst_act_reg <= 1'b1;
        end
        else if (ce)
        begin
            if (rst_req)
            begin
                rst_cnt_reg <= 10'(RESET_TICKS);
                rst_act_reg <= 1'b1;
            end
            else if (rst_act_reg && tick)
            begin
                rst_cnt_reg <= rst_cnt_reg - 10'h001;
                if (rst_cnt_reg == 10'h001)
                    rst_act_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_cnt_reg   <= 15'h0000;
            wd_first_reg <= 1'b1;
            trip_reg     <= 1'b0;
        end
        else if (ce)
        begin
            if (!wd_run || kick_evt || expire)
                wd_cnt_reg <= 15'h0000;
            else if (tick)
                wd_cnt_reg <= wd_cnt_reg + 15'h0001;
            if (rst_act_reg && !expire)
                wd_first_reg <= 1'b1;
            else if (kick_evt || expire)
                wd_first_reg <= 1'b0;
            // A clear arriving with the final tick wins, as expire excludes it.
            if (expire)
                trip_reg <= 1'b1;
            else if (kick_evt || open_s)
                trip_reg <= 1'b0;
        end
    end

    // Early warning filter; a good sample restarts the count.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ew_cnt_reg <= 2'h0;
            ew_reg     <= 1'b0;
        end
        else if (ce)
        begin
            if (!sen_low)
                ew_cnt_reg <= 2'h0;
            else if (smp_tick && ew_cnt_reg != `SSW_EW_SAMPLES)
                ew_cnt_reg <= ew_cnt_reg + 2'h1;
            if (!sen_low)
                ew_reg <= 1'b0;
            else if (ew_cnt_reg == `SSW_EW_SAMPLES && !sup_low)
                ew_reg <= 1'b1;
        end
    end

    // Every pin output is registered so glitches never reach the board.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reset_threshold_flag_n <= 1'b0;
            reset_out_n            <= 1'b0;
            reset_out              <= 1'b1;
            watchdog_trip_flag_n   <= 1'b1;
            ew_irq_n               <= 1'b1;
            ew_irq_oe              <= 1'b0;
            power_fail_flag        <= 1'b0;
            memory_enable_out_n    <= 1'b1;
        end
        else if (ce)
        begin
            reset_threshold_flag_n <= !sup_low;
            reset_out_n            <= !rst_req && !rst_act_reg;
            reset_out              <= rst_req || rst_act_reg;
            watchdog_trip_flag_n   <= !(trip_reg || expire || sup_low)
                                      || (open_s && !sup_low);
            ew_irq_n               <= !ew_reg || bat_low;
            ew_irq_oe              <= !bat_low;
            power_fail_flag        <= bat_low;
            memory_enable_out_n    <= cei_n_s || sup_low;
        end
    end

    // AXI4-Lite slave: address and data taken in either order.
    logic       aw_have_reg;
    logic       w_have_reg;
    logic [7:0] waddr_reg;
    logic [1:0] wbits_reg;
    logic       wlane_reg;
    wire  aw_hs   = s_axi_awvalid && s_axi_awready;
    wire  w_hs    = s_axi_wvalid && s_axi_wready;
    wire  do_wr   = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire  wr_ctrl = waddr_reg == `SSW_OFF_CTRL;
    wire  wr_ok   = wr_ctrl || waddr_reg == `SSW_OFF_STATUS;
    wire  ar_hs   = s_axi_arvalid && s_axi_arready;
    wire  rd_ctrl = s_axi_araddr == `SSW_OFF_CTRL;
    wire  rd_stat = s_axi_araddr == `SSW_OFF_STATUS;
    wire  [31:0] status = {26'h0000000, bat_low, open_s, sup_low,
                           ew_reg, trip_reg, rst_act_reg};
    wire  [31:0] rd_val = rd_ctrl ? {31'h00000000, ctrl_reg[0]}
                        : rd_stat ? status : 32'h00000000;

    assign kick_evt = hw_kick
                      || (do_wr && wr_ctrl && wlane_reg
                          && wbits_reg[`SSW_CTRL_KICK]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            waddr_reg     <= 8'h00;
            wbits_reg     <= 2'h0;
            wlane_reg     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SSW_RESP_OKAY;
            ctrl_reg      <= `SSW_CTRL_RESET;
        end
        else if (ce)
        begin
            if (aw_hs)
            begin
                aw_have_reg   <= 1'b1;
                waddr_reg     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_have_reg   <= 1'b1;
                wbits_reg    <= s_axi_wdata[1:0];
                wlane_reg    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? SSW_RESP_OKAY : SSW_RESP_SLVERR;
                if (wr_ctrl && wlane_reg)
                    ctrl_reg[0] <= wbits_reg[0];
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_have_reg   <= 1'b0;
                w_have_reg    <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= SSW_RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_hs)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= (rd_ctrl || rd_stat) ? SSW_RESP_OKAY
                                                      : SSW_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    sequence s_kick;
        ce && kick_evt && !expire;
    endsequence

    sequence s_expire;
        ce && expire;
    endsequence

    a_supply_low_resets: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && sup_low |=>
        !reset_threshold_flag_n && reset_out && !reset_out_n)
        else $error("supply low did not assert flag and resets");

    a_flag_release: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && !sup_low |=> reset_threshold_flag_n)
        else $error("threshold flag not released at once");

    a_stretch_hold: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && rst_act_reg && rst_cnt_reg > 10'h001
        |=> rst_act_reg && !reset_out_n)
        else $error("reset released before stretch ended");

    a_wd_stopped: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && (sup_low || rst_act_reg)
        |=> wd_cnt_reg == 15'h0000)
        else $error("watchdog counted while supply bad or in reset");

    a_kick_restart: assert property (@(posedge aclk)
        disable iff (!aresetn) s_kick |=> wd_cnt_reg == 15'h0000
        && !trip_reg)
        else $error("kick did not restart count and clear trip");

    a_trip_reset: assert property (@(posedge aclk)
        disable iff (!aresetn) s_expire |=> trip_reg && rst_act_reg
        ##1 !watchdog_trip_flag_n || open_s)
        else $error("timeout did not trip flag and reset");

    a_trip_latched: assert property (@(posedge aclk)
        disable iff (!aresetn) trip_reg && !(ce && (kick_evt || open_s))
        |=> trip_reg)
        else $error("trip flag dropped without a kick");

    a_open_release: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && open_s && !expire |=> !trip_reg)
        else $error("open kick input did not release trip");

    a_trip_low_supply: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && sup_low |=> !watchdog_trip_flag_n)
        else $error("trip flag not low with supply low");

    a_ew_filter: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && !ew_reg && ew_cnt_reg != 2'h3
        |=> !ew_reg)
        else $error("interrupt raised before three low samples");

    a_ew_blocked: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && !ew_reg && sup_low |=> !ew_reg)
        else $error("interrupt raised during power-up");

    a_ew_hold: assert property (@(posedge aclk)
        disable iff (!aresetn) ew_reg && sen_low |=> ew_reg)
        else $error("interrupt released without sense rise");

    a_ew_float: assert property (@(posedge aclk)
        disable iff (!aresetn) ce && bat_low |=> !ew_irq_oe)
        else $error("interrupt pin driven at battery level");

endmodule : ssw_top

// ===== tb.sv
// Self-checking bench for the supervisor, watchdog and register slave.
// Assumes the shortened tick, debounce and period parameters.
`timescale 1ns/1ns
`define CHK(g, e) \
    begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
`define WAITC(c, m) \
    begin n = 0; while (!(c) && n < (m)) begin @(posedge aclk); n++; end end
module testbench;
    import ssw_pkg::*;
    localparam int TK = 4;
    localparam int RT = 5;
    localparam int LT = 10;
    int           n, compares = 0, err_total = 0;
    ssw_word_type d;
    ssw_resp_type r;
    logic aclk = 0, aresetn = 0, ce = 1, supply_low = 0, sense_low = 0;
    logic battery_low = 0, kick_open = 0, button_n = 1, kick_run = 1;
    logic timebase_input = 0, timebase_select = 1, chip_enable_in_n = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tcnt = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    ssw_word_type s_axi_wdata = 0, s_axi_rdata;
    ssw_resp_type s_axi_bresp, s_axi_rresp;
    logic watchdog_kick, reset_threshold_flag_n, reset_out_n, reset_out;
    logic watchdog_trip_flag_n, ew_irq_n, ew_irq_oe, power_fail_flag;
    logic memory_enable_out_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    ssw_top #(.FIRST_TICKS(20), .LATER_TICKS(LT), .RESET_TICKS(RT),
        .INT_TICK_CYCLES(TK), .DEBOUNCE_CYCLES(8)) i_ssw_top (.*);
    ssw_proc_model i_ssw_proc_model (.aclk(aclk), .run(kick_run),
        .watchdog_kick(watchdog_kick));
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    // External timebase: one rising edge every eight bus cycles.
    always @(posedge aclk)
    begin
        tcnt <= tcnt + 8'h01;
        timebase_input <= tcnt[2];
    end
    task automatic wr(input logic [7:0] a, input ssw_word_type v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic t_powerup();
        @(posedge aclk);
        `CHK(reset_out_n, 1'b0)
        `WAITC(reset_out_n === 1'b1, 200)
        `CHK(n >= (RT - 1) * TK, 1'b1)
        `CHK(reset_out, 1'b0)
        `CHK(reset_threshold_flag_n, 1'b1)
    endtask : t_powerup
    task automatic t_supply();
        chip_enable_in_n <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK(memory_enable_out_n, 1'b0)
        supply_low <= 1'b1;
        kick_run <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK(reset_threshold_flag_n, 1'b0)
        `CHK({reset_out_n, reset_out}, 2'h1)
        `CHK(watchdog_trip_flag_n, 1'b0)
        `CHK(memory_enable_out_n, 1'b1)
        repeat (200) @(posedge aclk);
        supply_low <= 1'b0;
        kick_run <= 1'b1;
        repeat (5) @(posedge aclk);
        `CHK(reset_threshold_flag_n, 1'b1)
        `CHK(reset_out_n, 1'b0)
        `WAITC(reset_out_n === 1'b1, 100)
        `CHK(n >= RT * TK - 8, 1'b1)
        `CHK(watchdog_trip_flag_n, 1'b1)
        chip_enable_in_n <= 1'b1;
    endtask : t_supply
    task automatic t_button_ext();
        timebase_select <= 1'b0;
        repeat (20) @(posedge aclk);
        button_n <= 1'b0;
        repeat (28) @(posedge aclk);
        `CHK(reset_out_n, 1'b0)
        button_n <= 1'b1;
        `WAITC(reset_out_n === 1'b1, 200)
        `CHK(n >= (RT - 1) * 8, 1'b1)
        timebase_select <= 1'b1;
    endtask : t_button_ext
    task automatic t_watchdog();
        repeat (200) @(posedge aclk);
        `CHK({watchdog_trip_flag_n, reset_out_n}, 2'h3)
        kick_run <= 1'b0;
        `WAITC(watchdog_trip_flag_n === 1'b0, 100)
        `CHK(n <= LT * TK + 6, 1'b1)
        repeat (2) @(posedge aclk);
        `CHK(reset_out_n, 1'b0)
        `WAITC(reset_out_n === 1'b1, 100)
        `CHK(watchdog_trip_flag_n, 1'b0)
        kick_run <= 1'b1;
        `WAITC(watchdog_trip_flag_n === 1'b1, 40)
        `CHK(watchdog_trip_flag_n, 1'b1)
        kick_run <= 1'b0;
        kick_open <= 1'b1;
        repeat (200) @(posedge aclk);
        `CHK({watchdog_trip_flag_n, reset_out_n}, 2'h3)
        kick_open <= 1'b0;
        kick_run <= 1'b1;
    endtask : t_watchdog
    task automatic t_axi();
        rd(8'h00);
        `CHK({r, d[1:0]}, 4'h1)
        rd(8'h40);
        `CHK({r, d}, {SSW_RESP_SLVERR, 32'h00000000})
        wr(8'h40, 32'h00000001);
        `CHK(r, SSW_RESP_SLVERR)
        wr(8'h00, 32'h00000000);
        kick_run <= 1'b0;
        repeat (200) @(posedge aclk);
        `CHK(watchdog_trip_flag_n, 1'b1)
        kick_run <= 1'b1;
        wr(8'h00, 32'h00000001);
        `CHK(r, SSW_RESP_OKAY)
        kick_run <= 1'b0;
        repeat (6)
        begin
            wr(8'h00, 32'h00000003);
            repeat (20) @(posedge aclk);
        end
        `CHK(watchdog_trip_flag_n, 1'b1)
        kick_run <= 1'b1;
        rd(8'h04);
        `CHK({r, d[5:0]}, 8'h00)
    endtask : t_axi
    task automatic t_early();
        supply_low <= 1'b1;
        sense_low <= 1'b1;
        repeat (5000) @(posedge aclk);
        `CHK(ew_irq_n, 1'b1)
        supply_low <= 1'b0;
        sense_low <= 1'b0;
        `WAITC(reset_out_n === 1'b1, 100)
        sense_low <= 1'b1;
        repeat (3200) @(posedge aclk);
        `CHK(ew_irq_n, 1'b1)
        `WAITC(ew_irq_n === 1'b0, 1800)
        `CHK({ew_irq_n, ew_irq_oe}, 2'h1)
        battery_low <= 1'b1;
        repeat (5) @(posedge aclk);
        `CHK({power_fail_flag, ew_irq_oe}, 2'h2)
        battery_low <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK({power_fail_flag, ew_irq_oe}, 2'h1)
        `CHK(ew_irq_n, 1'b0)
        sense_low <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK(ew_irq_n, 1'b1)
    endtask : t_early
    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_powerup();
        t_supply();
        t_button_ext();
        t_watchdog();
        t_axi();
        t_early();
        test_done();
    end
    // A hang anywhere above ends the run here as a failure.
    initial
    begin
        repeat (40000) @(posedge aclk);
        err_total++;
        test_done();
    end
endmodule : testbench
